// file: tb/crs_register_set_monitor.sv
// crs_register_set_monitor: port assertions for the cpu register set
// assumes a bind onto crs_register_set, one mclk domain
`timescale 1ns/10ps
module crs_register_set_monitor
    import crs_pkg::*;
(
    input wire logic           mclk,
    input wire logic           rst_b,
    input wire logic [4:0]     reg_addr,
    input wire logic [15:0]    reg_wdata,
    input wire logic           reg_we,
    input wire logic           reg_re,
    input wire logic [15:0]    reg_rdata_q,
    input wire logic           alu_upd,
    input wire crs_alu_flags_t alu_flags,
    input wire logic           pc_load,
    input wire logic [19:0]    pc_next,
    input wire logic           instr_done,
    input wire logic           int_req,
    input wire logic [2:0]     int_level,
    input wire logic           int_maskable,
    input wire logic           int_ack,
    input wire logic           sw_int,
    input wire logic [5:0]     sw_int_num,
    input wire crs_flag_word_t flag_word_q,
    input wire logic [19:0]    program_counter_q,
    input wire logic           int_accept_q,
    input wire logic           step_int_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    wire acc_c  = int_req && (int_level > flag_word_q.priority_level)
                  && (!int_maskable || flag_word_q.int_enable);
    wire step_c = instr_done && flag_word_q.debug_step;
    // a flag write undisturbed by hardware updates, then read back
    sequence s_flag_wr;
        reg_we && reg_addr == IDX_FLAGS && !alu_upd && !int_ack && !sw_int;
    endsequence
    sequence s_flag_rd;
        reg_re && reg_addr == IDX_FLAGS;
    endsequence
    property p_flag_mask;
        s_flag_wr ##1 s_flag_rd
        |=> reg_rdata_q == ($past(reg_wdata, 2) & FLAG_WRITE_MASK);
    endproperty
    a_flag_mask: assert property (p_flag_mask)
        else $error("flag word read back with reserved bits set");
    property p_rsv;
        flag_word_q.rsv_15 == 1'b0 && flag_word_q.rsv_8 == 4'h0;
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved flag bits not zero");
    property p_alu;
        alu_upd |=> {flag_word_q.carry, flag_word_q.zero, flag_word_q.sign,
                     flag_word_q.overflow} == $past(alu_flags);
    endproperty
    a_alu: assert property (p_alu)
        else $error("alu flags not loaded");
    property p_ack;
        int_ack |=> !flag_word_q.debug_step && !flag_word_q.int_enable
                    && !flag_word_q.stack_sel;
    endproperty
    a_ack: assert property (p_ack)
        else $error("acknowledge did not clear flags");
    property p_sw_clr;
        sw_int && sw_int_num <= SW_INT_LAST_CLR |=> !flag_word_q.stack_sel;
    endproperty
    a_sw_clr: assert property (p_sw_clr)
        else $error("low software interrupt kept stack select");
    property p_sw_keep;
        sw_int && sw_int_num > SW_INT_LAST_CLR && !int_ack && !reg_we
        |=> $stable(flag_word_q.stack_sel);
    endproperty
    a_sw_keep: assert property (p_sw_keep)
        else $error("high software interrupt changed stack select");
    property p_accept;
        1'b1 |=> int_accept_q == $past(acc_c);
    endproperty
    a_accept: assert property (p_accept)
        else $error("interrupt acceptance wrong");
    property p_step;
        1'b1 |=> step_int_q == $past(step_c);
    endproperty
    a_step: assert property (p_step)
        else $error("single-step request wrong");
    property p_pc;
        pc_load |=> program_counter_q == $past(pc_next);
    endproperty
    a_pc: assert property (p_pc)
        else $error("program counter not loaded");
endmodule : crs_register_set_monitor

// file: tb/testbench.sv
// testbench: directed scenarios for crs_register_set
// assumes the 40 MHz mclk and synchronous active-low reset
`timescale 1ns/10ps
module testbench;
    import crs_pkg::*;
    logic           mclk, rst_b, reg_we, reg_re, pair_we, pair_re, alu_upd;
    logic           pc_load, instr_done, int_req, int_maskable, int_ack;
    logic           sw_int, int_accept_q, step_int_q;
    logic [4:0]     reg_addr, lo, hi;
    logic [15:0]    reg_wdata, reg_rdata_q;
    logic [1:0]     pair_sel;
    logic [31:0]    pair_wdata, pair_rdata_q;
    logic [19:0]    pc_next, program_counter_q, vector_table_base_q;
    logic [2:0]     int_level;
    logic [5:0]     sw_int_num;
    crs_alu_flags_t alu_flags;
    crs_flag_word_t flag_word_q;
    int             fails, comparisons;
    crs_register_set dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata_q(reg_rdata_q), .pair_sel(pair_sel),
        .pair_wdata(pair_wdata), .pair_we(pair_we), .pair_re(pair_re),
        .pair_rdata_q(pair_rdata_q), .alu_upd(alu_upd),
        .alu_flags(alu_flags), .pc_load(pc_load), .pc_next(pc_next),
        .instr_done(instr_done), .int_req(int_req), .int_level(int_level),
        .int_maskable(int_maskable), .int_ack(int_ack), .sw_int(sw_int),
        .sw_int_num(sw_int_num), .flag_word_q(flag_word_q),
        .program_counter_q(program_counter_q),
        .vector_table_base_q(vector_table_base_q),
        .int_accept_q(int_accept_q), .step_int_q(step_int_q));
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_we    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_we    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        @(posedge mclk);
        reg_re   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_re   <= 1'b0;
        #1 chk(reg_rdata_q, exp);
    endtask : rd
    // write then read back in the next cycle, no idle cycle between
    task automatic wrrd(input logic [4:0] a, input logic [15:0] d,
                        input logic [15:0] exp);
        @(posedge mclk);
        reg_we    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_we <= 1'b0;
        reg_re <= 1'b1;
        @(posedge mclk);
        reg_re <= 1'b0;
        #1 chk(reg_rdata_q, exp);
    endtask : wrrd
    localparam int S_PC   = 0;
    localparam int S_ALU  = 1;
    localparam int S_DONE = 2;
    localparam int S_ACK  = 3;
    localparam int S_SW   = 4;
    localparam int S_PRE  = 5;
    // pulse one strobe for a single cycle, then let its edge land
    task automatic pulse(input int k);
        @(posedge mclk);
        {pair_re, sw_int, int_ack, instr_done, alu_upd, pc_load} <= 6'(1 << k);
        @(posedge mclk);
        {pair_re, sw_int, int_ack, instr_done, alu_upd, pc_load} <= 6'h00;
        #1;
    endtask : pulse
    task automatic report_and_stop;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic t_bank;
        for (int p = 0; p < 4; p++)
        begin
            wr(IDX_FLAGS, 16'((p % 2) << 4));
            for (int i = 0; i < BANK_REGS; i++)
                if (p < 2)
                    wr(5'(i), 16'h1000 * 16'(p + 1) + 16'(i));
                else
                    rd(5'(i), 16'h1000 * 16'(p - 1) + 16'(i));
        end
        wr(IDX_D0_HIGH, 16'hFFAB);
        wr(IDX_D1_LOW, 16'h77CD);
        rd(IDX_DATA0, 16'hAB00);
        rd(5'h01, 16'h20CD);
        rd(IDX_D0_HIGH, 16'h00AB);
        rd(IDX_D1_LOW, 16'h00CD);
        wr(IDX_D0_LOW, 16'hEE12);
        wr(IDX_D1_HIGH, 16'hEE34);
        rd(IDX_DATA0, 16'hAB12);
        rd(5'h01, 16'h34CD);
        rd(IDX_D1_HIGH, 16'h0034);
    endtask : t_bank
    task automatic t_pair;
        for (int s = 0; s < 3; s++)
        begin
            lo = (s == 2) ? 5'h04 : 5'(s);
            hi = (s == 2) ? 5'h05 : 5'(s + 2);
            @(posedge mclk);
            pair_we    <= 1'b1;
            pair_sel   <= 2'(s);
            pair_wdata <= 32'h87654321 + 32'(s);
            @(posedge mclk);
            pair_we <= 1'b0;
            pair_re <= 1'b1;
            @(posedge mclk);
            pair_re <= 1'b0;
            #1 chk(pair_rdata_q, 32'h87654321 + 32'(s));
            rd(lo, 16'h4321 + 16'(s));
            rd(hi, 16'h8765);
        end
        pair_sel <= 2'h3;
        pulse(S_PRE);
        chk(pair_rdata_q, 32'h00000000);
    endtask : t_pair
    task automatic t_misc;
        wr(IDX_PC_LO, 16'hBEEF);
        wr(IDX_PC_HI, 16'hFFF5);
        #1 chk(program_counter_q, 20'h5BEEF);
        rd(IDX_PC_HI, 16'h0005);
        wr(IDX_VTB_LO, 16'h1234);
        wr(IDX_VTB_HI, 16'h000A);
        #1 chk(vector_table_base_q, 20'hA1234);
        pc_next <= 20'hF00D1;
        pulse(S_PC);
        chk(program_counter_q, 20'hF00D1);
        wr(IDX_USP, 16'h1111);
        wr(IDX_ISP, 16'h2222);
        wr(IDX_SB, 16'h3333);
        wr(IDX_FLAGS, 16'h0000);
        rd(IDX_SP, 16'h2222);
        wr(IDX_FLAGS, 16'h0080);
        rd(IDX_SP, 16'h1111);
        rd(IDX_SB, 16'h3333);
        rd(5'h1F, 16'h0000);
        wrrd(IDX_FLAGS, 16'hFFFF, 16'h70FF);
        for (int i = 0; i < 16; i++)
        begin
            alu_flags <= crs_alu_flags_t'(4'(i));
            pulse(S_ALU);
            rd(IDX_FLAGS, 16'h70D2 | {10'h000, i[0], 1'b0, i[1], i[2],
                1'b0, i[3]});
            chk({flag_word_q.carry, flag_word_q.zero, flag_word_q.sign,
                 flag_word_q.overflow}, 32'(i));
            chk(flag_word_q & 16'hFFD2, 16'h70D2);
        end
    endtask : t_misc
    task automatic t_int;
        wr(IDX_FLAGS, 16'h40C2);
        int_req      <= 1'b1;
        int_maskable <= 1'b1;
        for (int lv = 0; lv < 8; lv++)
        begin
            int_level <= 3'(lv);
            @(posedge mclk);
            @(posedge mclk);
            #1 chk(int_accept_q, 32'(lv > 4));
        end
        pulse(S_DONE);
        chk(step_int_q, 1);
        pulse(S_ACK);
        chk(flag_word_q, 16'h4000);
        @(posedge mclk);
        #1 chk(int_accept_q, 0);
        int_maskable <= 1'b0;
        @(posedge mclk);
        @(posedge mclk);
        #1 chk(int_accept_q, 1);
        pulse(S_DONE);
        chk(step_int_q, 0);
        wr(IDX_FLAGS, 16'h0080);
        for (int n = 32; n > 30; n--)
        begin
            sw_int_num <= 6'(n);
            pulse(S_SW);
            chk(flag_word_q.stack_sel, 32'(n > 31));
        end
        int_req <= 1'b0;
    endtask : t_int
    initial
    begin
        {rst_b, reg_we, reg_re, pair_we, pair_re, alu_upd, pc_load} = '0;
        {instr_done, int_req, int_maskable, int_ack, sw_int} = '0;
        {reg_addr, reg_wdata, pair_sel, pair_wdata, pc_next} = '0;
        {int_level, sw_int_num, alu_flags} = '0;
        {fails, comparisons} = '0;
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        rd(IDX_FLAGS, 16'h0000);
        t_bank();
        t_pair();
        t_misc();
        t_int();
        report_and_stop();
    end
    // guards against a hang in any scenario
    initial
    begin
        #500000;
        fails++;
        report_and_stop();
    end
endmodule : testbench
bind crs_register_set crs_register_set_monitor u_mon (.mclk(mclk),
    .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata_q(reg_rdata_q),
    .alu_upd(alu_upd), .alu_flags(alu_flags), .pc_load(pc_load),
    .pc_next(pc_next), .instr_done(instr_done), .int_req(int_req),
    .int_level(int_level), .int_maskable(int_maskable), .int_ack(int_ack),
    .sw_int(sw_int), .sw_int_num(sw_int_num), .flag_word_q(flag_word_q),
    .program_counter_q(program_counter_q), .int_accept_q(int_accept_q),
    .step_int_q(step_int_q));

// file: verilog/crs_pkg.sv
// crs_pkg: constants, field layout and carrier types of the cpu register set
// assumes the execution unit and register port share mclk
package crs_pkg;

    localparam int unsigned ADDR_W   = 5;
    localparam int unsigned WORD_W   = 16;
    localparam int unsigned PC_W     = 20;
    localparam int unsigned BANK_REGS = 7;

    // register port indexes; 0..6 address the active bank
    localparam logic [4:0] IDX_DATA0    = 5'h00;
    localparam logic [4:0] IDX_FB       = 5'h06;
    localparam logic [4:0] IDX_PC_LO    = 5'h07;
    localparam logic [4:0] IDX_PC_HI    = 5'h08;
    localparam logic [4:0] IDX_VTB_LO   = 5'h09;
    localparam logic [4:0] IDX_VTB_HI   = 5'h0A;
    localparam logic [4:0] IDX_USP      = 5'h0B;
    localparam logic [4:0] IDX_ISP      = 5'h0C;
    localparam logic [4:0] IDX_SB       = 5'h0D;
    localparam logic [4:0] IDX_FLAGS    = 5'h0E;
    localparam logic [4:0] IDX_SP       = 5'h0F;
    localparam logic [4:0] IDX_D0_LOW   = 5'h10;
    localparam logic [4:0] IDX_D0_HIGH  = 5'h11;
    localparam logic [4:0] IDX_D1_LOW   = 5'h12;
    localparam logic [4:0] IDX_D1_HIGH  = 5'h13;

    // pair selector values
    localparam logic [1:0] PAIR_DATA_LOW  = 2'h0;
    localparam logic [1:0] PAIR_DATA_HIGH = 2'h1;
    localparam logic [1:0] PAIR_ADDRESS   = 2'h2;

    // bank slots
    localparam int unsigned SLOT_D0 = 0;
    localparam int unsigned SLOT_D1 = 1;
    localparam int unsigned SLOT_D2 = 2;
    localparam int unsigned SLOT_D3 = 3;
    localparam int unsigned SLOT_A0 = 4;
    localparam int unsigned SLOT_A1 = 5;

    localparam logic [15:0] FLAG_WRITE_MASK = 16'h70FF;
    localparam logic [15:0] FLAG_RESET      = 16'h0000;
    localparam logic [15:0] WORD_RESET      = 16'h0000;
    localparam logic [19:0] PC_RESET        = 20'h00000;
    localparam logic [5:0]  SW_INT_LAST_CLR = 6'h1F;

    typedef struct packed {
        logic       rsv_15;
        logic [2:0] priority_level;
        logic [3:0] rsv_8;
        logic       stack_sel;
        logic       int_enable;
        logic       overflow;
        logic       bank_sel;
        logic       sign;
        logic       zero;
        logic       debug_step;
        logic       carry;
    } crs_flag_word_t;

    typedef struct packed {
        logic carry;
        logic zero;
        logic sign;
        logic overflow;
    } crs_alu_flags_t;

endpackage : crs_pkg

// file: verilog/crs_register_set.sv
// crs_register_set: programmer-visible cpu registers and flag word
// assumes the execution unit drives all strobes on mclk, one cycle each
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/10ps
module crs_register_set
(
    input  wire logic                     mclk,
    input  wire logic                     rst_b,
    input  wire logic [4:0]               reg_addr,
    input  wire logic [15:0]              reg_wdata,
    input  wire logic                     reg_we,
    input  wire logic                     reg_re,
    output logic [15:0]                   reg_rdata_q,
    input  wire logic [1:0]               pair_sel,
    input  wire logic [31:0]              pair_wdata,
    input  wire logic                     pair_we,
    input  wire logic                     pair_re,
    output logic [31:0]                   pair_rdata_q,
    input  wire logic                     alu_upd,
    input  wire crs_pkg::crs_alu_flags_t  alu_flags,
    input  wire logic                     pc_load,
    input  wire logic [19:0]              pc_next,
    input  wire logic                     instr_done,
    input  wire logic                     int_req,
    input  wire logic [2:0]               int_level,
    input  wire logic                     int_maskable,
    input  wire logic                     int_ack,
    input  wire logic                     sw_int,
    input  wire logic [5:0]               sw_int_num,
    output crs_pkg::crs_flag_word_t       flag_word_q,
    output logic [19:0]                   program_counter_q,
    output logic [19:0]                   vector_table_base_q,
    output logic                          int_accept_q,
    output logic                          step_int_q
);
    import crs_pkg::*;

    logic [15:0]    bank_q [0:1][0:BANK_REGS-1];
    logic [15:0]    user_stack_ptr_q;
    logic [15:0]    interrupt_stack_ptr_q;
    logic [15:0]    static_base_q;
    logic           bank;
    logic           wr_flags;
    logic           wr_sp;
    logic [15:0]    flags_in;
    logic [15:0]    rd_d;
    logic [31:0]    pair_d;
    crs_flag_word_t flag_d;

    assign bank     = flag_word_q.bank_sel;
    assign wr_flags = reg_we && (reg_addr == IDX_FLAGS);
    assign wr_sp    = reg_we && (reg_addr == IDX_SP);
    assign flags_in = reg_wdata & FLAG_WRITE_MASK;

    // banked registers: word, byte-half and pair writes
    genvar gb;
    genvar gs;
    generate
        for (gb = 0; gb < 2; gb++)
        begin : g_bank
            for (gs = 0; gs < BANK_REGS; gs++)
            begin : g_slot
                localparam logic [4:0] IDX     = 5'(gs);
                localparam logic       BANK_ID = 1'(gb);
                always_ff @(posedge mclk)
                begin
                    if (!rst_b)
                        bank_q[gb][gs] <= WORD_RESET;
                    else if (bank == BANK_ID)
                    begin
                        if (reg_we && reg_addr == IDX)
                            bank_q[gb][gs] <= reg_wdata;
                        else if (reg_we && gs == SLOT_D0
                                 && reg_addr == IDX_D0_LOW)
                            bank_q[gb][gs][7:0] <= reg_wdata[7:0];
                        else if (reg_we && gs == SLOT_D0
                                 && reg_addr == IDX_D0_HIGH)
                            bank_q[gb][gs][15:8] <= reg_wdata[7:0];
                        else if (reg_we && gs == SLOT_D1
                                 && reg_addr == IDX_D1_LOW)
                            bank_q[gb][gs][7:0] <= reg_wdata[7:0];
                        else if (reg_we && gs == SLOT_D1
                                 && reg_addr == IDX_D1_HIGH)
                            bank_q[gb][gs][15:8] <= reg_wdata[7:0];
                        else if (pair_we)
                        begin
                            // upper word lands in the higher-numbered register
                            if (pair_sel == PAIR_DATA_LOW && gs == SLOT_D0)
                                bank_q[gb][gs] <= pair_wdata[15:0];
                            if (pair_sel == PAIR_DATA_LOW && gs == SLOT_D2)
                                bank_q[gb][gs] <= pair_wdata[31:16];
                            if (pair_sel == PAIR_DATA_HIGH && gs == SLOT_D1)
                                bank_q[gb][gs] <= pair_wdata[15:0];
                            if (pair_sel == PAIR_DATA_HIGH && gs == SLOT_D3)
                                bank_q[gb][gs] <= pair_wdata[31:16];
                            if (pair_sel == PAIR_ADDRESS && gs == SLOT_A0)
                                bank_q[gb][gs] <= pair_wdata[15:0];
                            if (pair_sel == PAIR_ADDRESS && gs == SLOT_A1)
                                bank_q[gb][gs] <= pair_wdata[31:16];
                        end
                    end
                end
            end
        end
    endgenerate

    // stack pointers; the alias index follows the stack select flag
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            user_stack_ptr_q      <= WORD_RESET;
            interrupt_stack_ptr_q <= WORD_RESET;
        end
        else
        begin
            if ((reg_we && reg_addr == IDX_USP)
                || (wr_sp && flag_word_q.stack_sel))
                user_stack_ptr_q <= reg_wdata;
            if ((reg_we && reg_addr == IDX_ISP)
                || (wr_sp && !flag_word_q.stack_sel))
                interrupt_stack_ptr_q <= reg_wdata;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            static_base_q <= WORD_RESET;
        else if (reg_we && reg_addr == IDX_SB)
            static_base_q <= reg_wdata;
    end

    // execution unit load beats a register-port write in the same cycle
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            program_counter_q <= PC_RESET;
        else if (pc_load)
            program_counter_q <= pc_next;
        else if (reg_we && reg_addr == IDX_PC_LO)
            program_counter_q[15:0] <= reg_wdata;
        else if (reg_we && reg_addr == IDX_PC_HI)
            program_counter_q[19:16] <= reg_wdata[3:0];
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            vector_table_base_q <= PC_RESET;
        else if (reg_we && reg_addr == IDX_VTB_LO)
            vector_table_base_q[15:0] <= reg_wdata;
        else if (reg_we && reg_addr == IDX_VTB_HI)
            vector_table_base_q[19:16] <= reg_wdata[3:0];
    end

    // flag word: software write, then alu update, then interrupt clears
    always_comb
    begin
        flag_d = flag_word_q;
        if (wr_flags)
            flag_d = crs_flag_word_t'(flags_in);
        if (alu_upd)
        begin
            // alu result wins over a write landing in the same cycle
            flag_d.carry    = alu_flags.carry;
            flag_d.zero     = alu_flags.zero;
            flag_d.sign     = alu_flags.sign;
            flag_d.overflow = alu_flags.overflow;
        end
        if (int_ack)
        begin
            // the handler must start unmasked-free and on the interrupt stack
            flag_d.debug_step = 1'b0;
            flag_d.int_enable = 1'b0;
            flag_d.stack_sel  = 1'b0;
        end
        if (sw_int && sw_int_num <= SW_INT_LAST_CLR)
            flag_d.stack_sel = 1'b0;
        flag_d.rsv_8  = 4'h0;
        flag_d.rsv_15 = 1'b0;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            flag_word_q <= crs_flag_word_t'(FLAG_RESET);
        else
            flag_word_q <= flag_d;
    end

    // single-step request, one cycle after the instruction retires
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            step_int_q <= 1'b0;
        else
            step_int_q <= instr_done && flag_word_q.debug_step;
    end

    // acceptance needs a level above the current one; non-maskable skip I
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            int_accept_q <= 1'b0;
        else
            int_accept_q <= int_req
                && (int_level > flag_word_q.priority_level)
                && (!int_maskable || flag_word_q.int_enable);
    end

    // register port read, answered in the next cycle; unmapped reads zero
    always_comb
    begin
        rd_d = WORD_RESET;
        case (reg_addr)
            IDX_PC_LO:   rd_d = program_counter_q[15:0];
            IDX_PC_HI:   rd_d = {12'h000, program_counter_q[19:16]};
            IDX_VTB_LO:  rd_d = vector_table_base_q[15:0];
            IDX_VTB_HI:  rd_d = {12'h000, vector_table_base_q[19:16]};
            IDX_USP:     rd_d = user_stack_ptr_q;
            IDX_ISP:     rd_d = interrupt_stack_ptr_q;
            IDX_SB:      rd_d = static_base_q;
            IDX_FLAGS:   rd_d = 16'(flag_word_q) & FLAG_WRITE_MASK;
            IDX_SP:      rd_d = flag_word_q.stack_sel ? user_stack_ptr_q
                                : interrupt_stack_ptr_q;
            IDX_D0_LOW:  rd_d = {8'h00, bank_q[bank][SLOT_D0][7:0]};
            IDX_D0_HIGH: rd_d = {8'h00, bank_q[bank][SLOT_D0][15:8]};
            IDX_D1_LOW:  rd_d = {8'h00, bank_q[bank][SLOT_D1][7:0]};
            IDX_D1_HIGH: rd_d = {8'h00, bank_q[bank][SLOT_D1][15:8]};
            default:
            begin
                if (reg_addr <= IDX_FB)
                    rd_d = bank_q[bank][reg_addr[2:0]];
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            reg_rdata_q <= WORD_RESET;
        else if (reg_re)
            reg_rdata_q <= rd_d;
    end

    always_comb
    begin
        case (pair_sel)
            PAIR_DATA_LOW:  pair_d = {bank_q[bank][SLOT_D2],
                                      bank_q[bank][SLOT_D0]};
            PAIR_DATA_HIGH: pair_d = {bank_q[bank][SLOT_D3],
                                      bank_q[bank][SLOT_D1]};
            PAIR_ADDRESS:   pair_d = {bank_q[bank][SLOT_A1],
                                      bank_q[bank][SLOT_A0]};
            default:        pair_d = 32'h00000000;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            pair_rdata_q <= 32'h00000000;
        else if (pair_re)
            pair_rdata_q <= pair_d;
    end

endmodule : crs_register_set
